// file: hw/fcpwm_pkg.sv
// Register map, field layout, reset values and carrier types of the four-channel modulator.
package fcpwm_pkg;

    localparam int NCH = 4;
    localparam int AW  = 9;

    // Register indices; the byte address of each is four times its index.
    localparam logic [6:0] IDX_CLK   = 7'h40;
    localparam logic [6:0] IDX_POL   = 7'h41;
    localparam logic [6:0] IDX_EN    = 7'h42;
    localparam logic [6:0] IDX_PRES  = 7'h43;
    localparam logic [6:0] IDX_SCAL0 = 7'h44;
    localparam logic [6:0] IDX_SCNT0 = 7'h45;
    localparam logic [6:0] IDX_CNT0  = 7'h48;
    localparam logic [6:0] IDX_PER0  = 7'h4C;
    localparam logic [6:0] IDX_DTY0  = 7'h50;
    localparam logic [6:0] IDX_CTR   = 7'h54;

    // Fields of clock_prescale_and_concat.
    localparam int CLK_JOIN_LOWER = 6;
    localparam int CLK_PCKA_LSB   = 3;
    localparam int CLK_PCKB_LSB   = 0;
    localparam int CODE_W         = 3;

    // Fields of clock_select_and_polarity: start-high bits low, scaled-clock selects high.
    localparam int POL_START_LSB = 0;
    localparam int POL_SEL_LSB   = 4;

    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [7:0] RST_PER  = 8'hFF;
    localparam logic [7:0] RST_DTY  = 8'h00;

    localparam logic [7:0]  ZERO8  = 8'h00;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ONE16  = 16'h0001;
    localparam logic [6:0]  ONE7   = 7'h01;

    // Per-channel counter, active latches and write buffers.
    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] per;
        logic [7:0] per_buf;
        logic [7:0] duty;
        logic [7:0] duty_buf;
    } fcpwm_ch_s;

endpackage

// file: hw/fcpwm_top.sv
// Four-channel pulse-width modulator with Avalon-MM register slave and shared port pins.
module fcpwm_top (
    input  wire logic                       CORE_CLK,
    input  wire logic                       RST_N,
    input  wire logic [fcpwm_pkg::AW-1:0]   AVS_ADDRESS,
    input  wire logic                       AVS_READ,
    input  wire logic                       AVS_WRITE,
    input  wire logic [3:0]                 AVS_BYTEENABLE,
    input  wire logic [31:0]                AVS_WRITEDATA,
    output logic      [31:0]                AVS_READDATA,
    output logic                            AVS_WAITREQUEST,
    input  wire logic [fcpwm_pkg::NCH-1:0]  GPIO_OUT,
    input  wire logic [fcpwm_pkg::NCH-1:0]  GPIO_DIR,
    output logic      [fcpwm_pkg::NCH-1:0]  PIN_O,
    output logic      [fcpwm_pkg::NCH-1:0]  PIN_OE
);
    import fcpwm_pkg::*;

    // ****************************************************************
    // State and helpers
    // ****************************************************************
    logic [7:0]     clk_q;
    logic [7:0]     pol_q;
    logic [NCH-1:0] en_q;
    logic [NCH-1:0] ctr_q;
    logic [6:0]     pres_q;
    logic [7:0]     scal_q [2];
    logic [7:0]     scnt_q [2];
    logic [1:0]     half_q;
    fcpwm_ch_s      ch_q [NCH];
    logic [NCH-1:0] dir_q;
    logic           wait_q;

    logic [6:0]     idx;
    logic [7:0]     wd;
    logic           wen;
    logic           run;
    logic [1:0]     base_tk;
    logic [1:0]     scl_tk;
    logic [NCH-1:0] cat;
    logic [NCH-1:0] tk;
    logic [NCH-1:0] wcnt;
    logic [NCH-1:0] wper;
    logic [NCH-1:0] wdty;
    logic [NCH-1:0] cw;
    logic [NCH-1:0] roll;
    logic [NCH-1:0] lat;
    logic [NCH-1:0] ndir;
    logic [NCH-1:0] pwm;
    logic [NCH-1:0] drv;
    logic [1:0]     own [NCH];
    logic [15:0]    c16 [NCH];
    logic [15:0]    p16 [NCH];
    logic [15:0]    d16 [NCH];
    logic [15:0]    n16 [NCH];
    logic [7:0]     rd8;
    logic           wr_clk;
    logic           wr_pol;
    logic           wr_en;
    logic           wr_ctr;
    logic [1:0]     wr_scal;
    logic           rd_go;
    logic [NCH-1:0] pin_oe_d;
    logic [NCH-1:0] pin_o_d;

    // Power-of-two prescale tap: the prescale counter's low bits are all ones.
    function automatic logic div_tick(input logic [CODE_W-1:0] code, input logic [6:0] cnt);
        logic [6:0] mask;
        mask = 7'((8'h01 << code) - 8'h01);
        return (cnt & mask) == mask;
    endfunction

    // Sixteen-bit view of a channel, with the partner as high byte when joined.
    function automatic logic [15:0] join16(input logic c, input logic [7:0] hi,
                                           input logic [7:0] lo);
        return c ? {hi, lo} : {ZERO8, lo};
    endfunction

    // True when an accepted write addresses the given register index.
    function automatic logic reg_hit(input logic [6:0] at, input logic [6:0] target,
                                     input logic strobe);
        return strobe && (at == target);
    endfunction

    // True when the index falls in the four-register bank that starts at base.
    function automatic logic in_bank(input logic [6:0] at, input logic [6:0] base);
        return at[6:2] == base[6:2];
    endfunction

    assign idx             = AVS_ADDRESS[AW-1:2];
    assign wd              = AVS_WRITEDATA[7:0];
    // A write lands only at the edge where the master sees waitrequest low.
    assign wen             = AVS_WRITE && !wait_q && AVS_BYTEENABLE[0];
    assign AVS_WAITREQUEST = wait_q;

    // ****************************************************************
    // Register write decode
    // ****************************************************************
    // One strobe per writable control register, so each update block reads one name.
    always_comb begin
        wr_clk = reg_hit(idx, IDX_CLK, wen);
        wr_pol = reg_hit(idx, IDX_POL, wen);
        wr_en  = reg_hit(idx, IDX_EN, wen);
        wr_ctr = reg_hit(idx, IDX_CTR, wen);
        for (int p = 0; p < 2; p++) begin
            wr_scal[p] = reg_hit(idx, 7'(int'(IDX_SCAL0) + 2 * p), wen);
        end
    end

    // ****************************************************************
    // Clock sources and channel next state
    // ****************************************************************
    always_comb begin
        run        = |en_q;
        // Clock sources are enables on the bus clock, so selecting one never glitches.
        base_tk[0] = run && div_tick(clk_q[CLK_PCKA_LSB +: CODE_W], pres_q);
        base_tk[1] = run && div_tick(clk_q[CLK_PCKB_LSB +: CODE_W], pres_q);
        for (int p = 0; p < 2; p++) begin
            scl_tk[p] = base_tk[p] && (scnt_q[p] == ZERO8) && half_q[p];
        end
        for (int i = 0; i < NCH; i++) begin
            cat[i]  = ((i % 2) == 1) && clk_q[CLK_JOIN_LOWER + i / 2];
            // A joined even channel follows its odd partner; its own logic is idle.
            own[i]  = 2'(i + ((((i % 2) == 0) && clk_q[CLK_JOIN_LOWER + i / 2]) ? 1 : 0));
            wcnt[i] = reg_hit(idx, 7'(int'(IDX_CNT0) + i), wen);
            wper[i] = reg_hit(idx, 7'(int'(IDX_PER0) + i), wen);
            wdty[i] = reg_hit(idx, 7'(int'(IDX_DTY0) + i), wen);
            tk[i]   = pol_q[POL_SEL_LSB + i] ? scl_tk[i / 2] : base_tk[i / 2];
            c16[i]  = join16(cat[i], ch_q[i ^ 1].cnt, ch_q[i].cnt);
            p16[i]  = join16(cat[i], ch_q[i ^ 1].per, ch_q[i].per);
            d16[i]  = join16(cat[i], ch_q[i ^ 1].duty, ch_q[i].duty);
            cw[i]   = wcnt[i] || (cat[i] && wcnt[i ^ 1]);
            n16[i]  = c16[i];
            ndir[i] = dir_q[i];
            roll[i] = 1'b0;
            if (cw[i]) begin
                n16[i]  = ZERO16;
                ndir[i] = 1'b0;
            end else if (en_q[i] && tk[i]) begin
                if (!ctr_q[i]) begin
                    if (c16[i] >= p16[i]) begin
                        n16[i]  = ZERO16;
                        roll[i] = 1'b1;
                    end else begin
                        n16[i] = c16[i] + ONE16;
                    end
                end else if (p16[i] == ZERO16) begin
                    n16[i]  = ZERO16;
                    ndir[i] = 1'b0;
                    roll[i] = 1'b1;
                end else if (!dir_q[i]) begin
                    if (c16[i] >= p16[i]) begin
                        n16[i]  = c16[i] - ONE16;
                        ndir[i] = 1'b1;
                    end else begin
                        n16[i] = c16[i] + ONE16;
                    end
                end else if (c16[i] <= ONE16) begin
                    n16[i]  = ZERO16;
                    ndir[i] = 1'b0;
                    roll[i] = 1'b1;
                end else begin
                    n16[i] = c16[i] - ONE16;
                end
            end
            lat[i] = roll[i] || cw[i] || !en_q[i];
            // Duty zero or above the period gives a fully active or inactive output.
            pwm[i] = ctr_q[i] ? (c16[i] < d16[i])
                              : ((c16[i] >= d16[i]) ^ pol_q[POL_START_LSB + i]);
            drv[i] = en_q[own[i]] && !cat[i];
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_q <= RST_REG8;
            pol_q <= RST_REG8;
            en_q  <= '0;
            ctr_q <= '0;
        end else begin
            if (wr_clk) begin
                clk_q <= wd;
            end
            if (wr_pol) begin
                pol_q <= wd;
            end
            if (wr_en) begin
                en_q <= wd[NCH-1:0];
            end
            if (wr_ctr) begin
                ctr_q <= wd[NCH-1:0];
            end
        end
    end

    // ****************************************************************
    // Prescaler and scalers
    // ****************************************************************
    // The prescaler freezes while every channel is off; it resumes from where it
    // stopped, so the first prescaled tick after an enable may come early.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pres_q <= '0;
        end else if (run) begin
            pres_q <= pres_q + ONE7;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            scal_q <= '{RST_REG8, RST_REG8};
            scnt_q <= '{RST_REG8, RST_REG8};
            half_q <= '0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (wr_scal[p]) begin
                    scal_q[p] <= wd;
                    scnt_q[p] <= wd;
                end else if (base_tk[p]) begin
                    if (scnt_q[p] == ZERO8) begin
                        scnt_q[p] <= scal_q[p];
                        half_q[p] <= !half_q[p];
                    end else begin
                        scnt_q[p] <= scnt_q[p] - 8'h01;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Channel counters and double buffers
    // ****************************************************************
    // In a joined pair the even channel stores the high byte only; its own enable,
    // clock select, polarity and alignment bits are ignored while joined.
    // Counters keep their value when a channel is disabled, so software must clear
    // the counter before a new enable to avoid a truncated first period.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < NCH; i++) begin
                ch_q[i] <= '{cnt: RST_REG8, per: RST_PER, per_buf: RST_PER,
                             duty: RST_DTY, duty_buf: RST_DTY};
            end
            dir_q <= '0;
        end else begin
            dir_q <= ndir;
            for (int i = 0; i < NCH; i++) begin
                ch_q[i].cnt <= (own[i] != 2'(i)) ? n16[own[i]][15:8] : n16[i][7:0];
                if (wper[i]) begin
                    ch_q[i].per_buf <= wd;
                end
                if (wdty[i]) begin
                    ch_q[i].duty_buf <= wd;
                end
                if (lat[own[i]]) begin
                    ch_q[i].per  <= wper[i] ? wd : ch_q[i].per_buf;
                    ch_q[i].duty <= wdty[i] ? wd : ch_q[i].duty_buf;
                end
            end
        end
    end

    // ****************************************************************
    // Register slave
    // ****************************************************************
    always_comb begin
        rd8 = ZERO8;
        if (in_bank(idx, IDX_CNT0)) begin
            rd8 = ch_q[idx[1:0]].cnt;
        end else if (in_bank(idx, IDX_PER0)) begin
            rd8 = ch_q[idx[1:0]].per_buf;
        end else if (in_bank(idx, IDX_DTY0)) begin
            rd8 = ch_q[idx[1:0]].duty_buf;
        end else begin
            unique case (idx)
                IDX_CLK:       rd8 = clk_q;
                IDX_POL:       rd8 = pol_q;
                IDX_EN:        rd8 = {4'h0, en_q};
                IDX_PRES:      rd8 = {1'b0, pres_q};
                IDX_SCAL0:     rd8 = scal_q[0];
                IDX_SCNT0:     rd8 = scnt_q[0];
                IDX_SCAL0 + 2: rd8 = scal_q[1];
                IDX_SCNT0 + 2: rd8 = scnt_q[1];
                IDX_CTR:       rd8 = {4'h0, ctr_q};
                default:       rd8 = ZERO8;
            endcase
        end
    end

    // One wait cycle per access keeps read data registered.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wait_q <= 1'b1;
        end else if (!wait_q) begin
            wait_q <= 1'b1;
        end else if (AVS_READ || AVS_WRITE) begin
            wait_q <= 1'b0;
        end
    end

    // Read data is captured only when a read is taken and holds through writes,
    // so a master that samples late still sees the value it asked for.
    assign rd_go = AVS_READ && wait_q;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            AVS_READDATA <= '0;
        end else if (rd_go) begin
            AVS_READDATA <= {24'h00_0000, rd8};
        end
    end

    // ****************************************************************
    // Port pins
    // ****************************************************************
    // An enabled channel overrides the port direction without touching it, so the
    // port setting returns as soon as the channel is disabled again.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            pin_oe_d[i] = drv[i] ? 1'b1 : GPIO_DIR[i];
            pin_o_d[i]  = drv[i] ? pwm[own[i]] : GPIO_OUT[i];
        end
    end

    // Both pin outputs are registered so that no decode glitch reaches a pad.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PIN_OE <= '0;
        end else begin
            PIN_OE <= pin_oe_d;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PIN_O <= '0;
        end else begin
            PIN_O <= pin_o_d;
        end
    end

endmodule

// file: testbench/fcpwm_pin_load.sv
// Load on the four shared port pins, with weak pull-ups where nothing drives.
module fcpwm_pin_load (
    input  wire logic [3:0] pin_o,
    input  wire logic [3:0] pin_oe,
    output logic      [3:0] level
);
    timeunit 1ns;
    timeprecision 100ps;
    // A released pin floats up, so a stale driven low cannot pass for a match.
    always_comb level = (pin_o & pin_oe) | ~pin_oe;
endmodule

// file: testbench/fcpwm_properties.sv
// Concurrent checks on the register bus and pin ports of the modulator.
module fcpwm_properties (
    input wire logic                     CORE_CLK,
    input wire logic                     RST_N,
    input wire logic [fcpwm_pkg::AW-1:0] AVS_ADDRESS,
    input wire logic                     AVS_READ,
    input wire logic                     AVS_WRITE,
    input wire logic [3:0]               AVS_BYTEENABLE,
    input wire logic [31:0]              AVS_WRITEDATA,
    input wire logic [31:0]              AVS_READDATA,
    input wire logic                     AVS_WAITREQUEST,
    input wire logic [3:0]               GPIO_OUT,
    input wire logic [3:0]               GPIO_DIR,
    input wire logic [3:0]               PIN_O,
    input wire logic [3:0]               PIN_OE
);
    import fcpwm_pkg::*;
    // ****
    // Shadow of enable and join bits
    // ****
    logic [3:0] en_q;
    logic [1:0] join_q;
    logic [3:0] pin_own;
    logic [6:0] idx;
    logic       acc_w;
    assign idx = AVS_ADDRESS[8:2];
    assign acc_w = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) en_q <= 4'h0;
        else if (acc_w && idx == IDX_EN) en_q <= AVS_WRITEDATA[3:0];
    end
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) join_q <= 2'h0;
        else if (acc_w && idx == IDX_CLK) join_q <= AVS_WRITEDATA[7:6];
    end
    // A joined pair is driven by the odd channel's enable on the even pin.
    assign pin_own = {~join_q[1] & en_q[3], join_q[1] ? en_q[3] : en_q[2],
                      ~join_q[0] & en_q[1], join_q[0] ? en_q[1] : en_q[0]};
    // ****
    // Properties
    // ****
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_taken;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence s_answer;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    a_one_wait: assert property (s_taken |=> s_answer)
        else $error("bus answer not one cycle after request");
    a_no_spurious: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("bus answered without request");
    a_data_upper: assert property (AVS_READDATA[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_data_hold: assert property (AVS_WAITREQUEST && !AVS_READ |=> $stable(AVS_READDATA))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (s_taken and AVS_READ && (idx < IDX_CLK || idx > IDX_CTR)
        |=> AVS_READDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_enable_back: assert property (s_taken and AVS_READ && idx == IDX_EN
        |=> AVS_READDATA == {28'h000_0000, en_q})
        else $error("enable readback wrong");
    a_pin_owner: assert property (RST_N |=> PIN_OE == ($past(pin_own) | $past(GPIO_DIR)))
        else $error("pin enable does not match owner");
    a_gpio_pass: assert property (RST_N |=> ((PIN_O ^ $past(GPIO_OUT)) & ~$past(pin_own)) == 4'h0)
        else $error("free pin does not follow port data");
endmodule

bind fcpwm_top fcpwm_properties i_fcpwm_properties (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .GPIO_OUT(GPIO_OUT),
    .GPIO_DIR(GPIO_DIR), .PIN_O(PIN_O), .PIN_OE(PIN_OE));

// file: testbench/fcpwm_test.sv
// Self-checking bench for the four-channel modulator.
module fcpwm_test;
    timeunit 1ns;
    timeprecision 100ps;
    import fcpwm_pkg::*;
    logic          clk, rst_n, rd, wr, waitreq;
    logic [AW-1:0] addr;
    logic [3:0]    be, gout, gdir, pin_o, pin_oe, lvl;
    logic [31:0]   wdata, rdata;
    logic [7:0]    q;
    int            mismatches, n_compared;
    fcpwm_top i_fcpwm_top (.CORE_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .GPIO_OUT(gout), .GPIO_DIR(gdir), .PIN_O(pin_o),
        .PIN_OE(pin_oe));
    fcpwm_pin_load i_fcpwm_pin_load (.pin_o(pin_o), .pin_oe(pin_oe), .level(lvl));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        gout <= 4'($urandom);
        gdir <= 4'($urandom);
    end
    // ****
    // Tasks
    // ****
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [6:0] i, input logic [7:0] d);
        int n;
        addr <= {i, 2'b00};
        wr <= w;
        rd <= !w;
        wdata <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 40);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
        if (n >= 40) begin
            mismatches++;
            finish_test();
        end
    endtask
    task automatic wrt(input logic [6:0] i, input logic [7:0] d);
        bus(1'b1, i, d);
    endtask
    task automatic rdc(input logic [6:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00);
        chk({8'h00, q}, {8'h00, e});
    endtask
    // Counts high cycles over four whole periods, so the phase at the start does not matter.
    task automatic wave(input int c, input int per, input int duty, input int pol, input int ctr);
        int w, e, hi, ge, s;
        wrt(IDX_EN, 8'h00);
        wrt(IDX_CLK, 8'(c << CLK_PCKA_LSB));
        wrt(IDX_POL, 8'(pol));
        wrt(IDX_CTR, 8'(ctr));
        wrt(IDX_PER0, 8'(per));
        wrt(IDX_DTY0, 8'(duty));
        wrt(IDX_CNT0, 8'h00);
        wrt(IDX_EN, 8'h01);
        s = c + ((pol >> 4) & 1);
        w = (ctr != 0 ? 2 * per : per + 1) << s;
        repeat (2 * w) @(posedge clk);
        hi = 0;
        repeat (4 * w) begin
            @(posedge clk);
            hi += (lvl[0] === 1'b1);
        end
        ge = duty > per ? 0 : per + 1 - duty;
        if (ctr != 0) e = (duty > per ? per + 1 : duty) + (duty > 1 ? (duty > per ? per : duty) - 1 : 0);
        else e = (pol % 2) != 0 ? per + 1 - ge : ge;
        chk(16'(hi), 16'((4 * e) << s));
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        void'($urandom(36864));
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = '0;
        be = 4'hF;
        wdata = 32'h0000_0000;
        gout = 4'h0;
        gdir = 4'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc(IDX_CLK, RST_REG8);
        rdc(IDX_POL, 8'h00);
        rdc(IDX_EN, 8'h00);
        rdc(7'h3F, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rdc(7'(IDX_PER0 + i), 8'hFF);
            rdc(7'(IDX_DTY0 + i), 8'h00);
            rdc(7'(IDX_CNT0 + i), 8'h00);
        end
        wrt(IDX_PRES, 8'h55);
        rdc(IDX_PRES, 8'h00);
        be <= 4'h0;
        wrt(IDX_POL, 8'hFF);
        be <= 4'hF;
        rdc(IDX_POL, 8'h00);
        $display("registers after reset done");
        for (int i = 0; i < 6; i++) begin
            logic [7:0] v;
            v = 8'($urandom);
            wrt(IDX_POL, v);
            rdc(IDX_POL, v);
            wrt(IDX_CLK, v);
            rdc(IDX_CLK, v);
            wrt(IDX_EN, v);
            rdc(IDX_EN, v & 8'h0F);
            repeat (10) @(posedge clk);
        end
        $display("register access done");
        wave(0, 3, 0, 0, 0);
        wave(0, 3, 4, 0, 0);
        wave(0, 3, 1, 1, 0);
        for (int i = 0; i < 8; i++) begin
            int per;
            per = 1 + $urandom % 7;
            wave($urandom % 3, per, $urandom % (per + 2), $urandom % 32, i % 2);
        end
        $display("waveforms done");
        wrt(IDX_EN, 8'h00);
        bus(1'b0, IDX_CNT0, 8'h00);
        repeat (20) @(posedge clk);
        rdc(IDX_CNT0, q);
        wrt(IDX_CNT0, 8'h5A);
        rdc(IDX_CNT0, 8'h00);
        $display("counter access done");
        finish_test();
    end
endmodule
